/* include/debug_trigger_pkg.sv */
package debug_trigger_pkg;

    // =========================================================
    // Widths and depths
    localparam int ADDR_W      = 16;
    localparam int DATA_W      = 8;
    localparam int REG_AW      = 3;
    localparam int REG_DW      = 16;
    localparam int FIFO_DEPTH  = 8;
    localparam int PTR_W       = 3;
    localparam int CNT_W       = 4;
    localparam int QUEUE_DEPTH = 4;
    localparam int QCNT_W      = 3;

    // =========================================================
    // Register offsets
    localparam logic [2:0] OFS_COMP_A = 3'h0;
    localparam logic [2:0] OFS_COMP_B = 3'h1;
    localparam logic [2:0] OFS_CTRL   = 3'h2;
    localparam logic [2:0] OFS_TRIG   = 3'h3;
    localparam logic [2:0] OFS_STAT   = 3'h4;
    localparam logic [2:0] OFS_FIFO   = 3'h5;

    // =========================================================
    // Field positions
    localparam int CTRL_ENABLE  = 7;
    localparam int CTRL_ARM     = 6;
    localparam int CTRL_TAG     = 5;
    localparam int CTRL_BRK_EN  = 4;
    localparam int CTRL_A_DIR_Q = 3;
    localparam int CTRL_A_DIR_V = 2;
    localparam int CTRL_B_DIR_Q = 1;
    localparam int CTRL_B_DIR_V = 0;
    localparam int TRIG_OQS     = 7;
    localparam int TRIG_BEGIN   = 6;
    localparam int TRIG_MODE_HI = 3;
    localparam int STAT_AF      = 7;
    localparam int STAT_BF      = 6;
    localparam int STAT_ARMED_FLAG    = 5;

    // =========================================================
    // Reset values and full FIFO count
    localparam logic [15:0] COMP_RESET = 16'h0000;
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [7:0]  TRIG_RESET = 8'h00;
    localparam logic [3:0]  CNT_FULL   = 4'h8;

    typedef enum logic [3:0] {
        MODE_A_ONLY     = 4'h0,
        MODE_A_OR_B     = 4'h1,
        MODE_A_THEN_B   = 4'h2,
        MODE_EVT_B      = 4'h3,
        MODE_A_THEN_EVT = 4'h4,
        MODE_FULL_AND   = 4'h5,
        MODE_FULL_NAND  = 4'h6,
        MODE_INSIDE     = 4'h7,
        MODE_OUTSIDE    = 4'h8
    } trig_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  rdata;
        logic [7:0]  wdata;
        logic        rw;
        logic        valid;
        logic        bdc;
    } cpu_bus_t;

    typedef struct packed {
        logic push;
        logic pop;
        logic flush;
    } queue_ev_t;

    typedef struct packed {
        logic tag;
        logic force_brk;
        logic use_swi;
    } bkpt_req_t;

endpackage

/* src/opcode_tracker.sv */
`timescale 1ns/1ps
module opcode_tracker (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Instruction queue events
    input  wire debug_trigger_pkg::queue_ev_t queue_i,
    input  wire logic                        match_i,
    // Opcode at queue end executes and was marked
    output logic                             hit_o
);
    typedef struct packed {
        logic [debug_trigger_pkg::QUEUE_DEPTH-1:0] tags;
        logic [debug_trigger_pkg::QCNT_W-1:0]      cnt;
    } trk_t;

    trk_t s;
    trk_t next_s;

    // =========================================================
    // Tag shift queue
    // Each slot follows one opcode, so several marks ride at once
    assign hit_o = queue_i.pop && (s.cnt != '0) && s.tags[0];

    always_comb begin
        next_s = s;
        if (queue_i.flush) begin
            // Discarded opcodes drop their marks unexecuted
            next_s = '0;
        end else begin
            if (queue_i.pop && s.cnt != '0) begin
                next_s.tags = s.tags >> 1;
                next_s.cnt  = s.cnt - 1'b1;
            end
            if (queue_i.push &&
                next_s.cnt < debug_trigger_pkg::QCNT_W'(debug_trigger_pkg::QUEUE_DEPTH)) begin
                next_s.tags[next_s.cnt[1:0]] = match_i;
                next_s.cnt = next_s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // opcode_tracker

/* src/debug_trigger_breakpoint_logic.sv */
`timescale 1ns/1ps
module debug_trigger_breakpoint_logic (
    // Clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    // Register port
    input  wire logic [2:0]                     reg_addr_i,
    input  wire logic [15:0]                    reg_wdata_i,
    input  wire logic                           reg_wr_i,
    input  wire logic                           reg_rd_i,
    output logic [15:0]                         reg_rdata_o,
    // CPU bus cycle
    input  wire debug_trigger_pkg::cpu_bus_t    bus_i,
    // Instruction queue
    input  wire debug_trigger_pkg::queue_ev_t   queue_i,
    // Change-of-flow address
    input  wire logic                           cof_valid_i,
    input  wire logic [15:0]                    cof_addr_i,
    // Background permit held by the serial controller
    input  wire logic                           background_permit_i,
    // Breakpoint request to the CPU
    output debug_trigger_pkg::bkpt_req_t        bkpt_o
);
    typedef struct packed {
        logic [15:0]      comp_a;
        logic [15:0]      comp_b;
        logic [7:0]       ctrl;
        logic [7:0]       trig;
        logic             armed;
        logic             a_flag;
        logic             b_flag;
        logic             storing;
        logic [7:0][15:0] fifo;
        logic [2:0]       wptr;
        logic [2:0]       rptr;
        logic [3:0]       count;
        logic [15:0]      rdata;
        debug_trigger_pkg::bkpt_req_t bkpt;
    } state_t;

    state_t s;
    state_t next_s;

    debug_trigger_pkg::trig_mode_t mode;
    logic       cyc_ok;
    logic       dir_a_ok;
    logic       dir_b_ok;
    logic       addr_a_eq;
    logic       addr_b_eq;
    logic       match_a;
    logic       match_b;
    logic       hit_a;
    logic       hit_b;
    logic       ev_a;
    logic       ev_b;
    logic [7:0] data_sel;
    logic       data_eq;
    logic       full_mode;
    logic       event_mode;
    logic       end_trace;
    logic       trig_ev;
    logic       brk_ev;
    logic       tag_sel;
    logic       pop;
    logic       push;
    logic       full;
    logic [15:0] push_word;

    // =========================================================
    // Comparators
    assign mode = debug_trigger_pkg::trig_mode_t'(s.trig[debug_trigger_pkg::TRIG_MODE_HI:0]);
    // Debugger traffic must never look like user activity
    assign cyc_ok = bus_i.valid && !bus_i.bdc;

    assign dir_a_ok = !s.ctrl[debug_trigger_pkg::CTRL_A_DIR_Q] ||
                      (bus_i.rw == s.ctrl[debug_trigger_pkg::CTRL_A_DIR_V]);
    assign dir_b_ok = !s.ctrl[debug_trigger_pkg::CTRL_B_DIR_Q] ||
                      (bus_i.rw == s.ctrl[debug_trigger_pkg::CTRL_B_DIR_V]);

    assign addr_a_eq = bus_i.addr == s.comp_a;
    assign addr_b_eq = bus_i.addr == s.comp_b;
    assign match_a   = cyc_ok && addr_a_eq && dir_a_ok;
    assign match_b   = cyc_ok && addr_b_eq && dir_b_ok;

    // Write data bus only when A is qualified on writes
    always_comb begin
        if (s.ctrl[debug_trigger_pkg::CTRL_A_DIR_Q] && !s.ctrl[debug_trigger_pkg::CTRL_A_DIR_V]) begin
            data_sel = bus_i.wdata;
        end else begin
            data_sel = bus_i.rdata;
        end
    end
    // Upper byte of comparator B plays no part in data compares
    assign data_eq = data_sel == s.comp_b[7:0];

    // =========================================================
    // Opcode tracking, one per comparator
    opcode_tracker trk_a (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .queue_i (queue_i),
        .match_i (match_a),
        .hit_o   (hit_a)
    );

    opcode_tracker trk_b (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .queue_i (queue_i),
        .match_i (match_b),
        .hit_o   (hit_b)
    );

    assign ev_a = s.trig[debug_trigger_pkg::TRIG_OQS] ? hit_a : match_a;
    assign ev_b = s.trig[debug_trigger_pkg::TRIG_OQS] ? hit_b : match_b;

    // =========================================================
    // Trigger mode selection
    assign full_mode  = (mode == debug_trigger_pkg::MODE_FULL_AND) ||
                        (mode == debug_trigger_pkg::MODE_FULL_NAND);
    assign event_mode = (mode == debug_trigger_pkg::MODE_EVT_B) ||
                        (mode == debug_trigger_pkg::MODE_A_THEN_EVT);
    // Event modes are always begin traces
    assign end_trace  = !event_mode && !s.trig[debug_trigger_pkg::TRIG_BEGIN];

    always_comb begin
        case (mode)
            debug_trigger_pkg::MODE_A_ONLY: begin
                trig_ev = ev_a;
            end
            debug_trigger_pkg::MODE_A_OR_B: begin
                trig_ev = ev_a || ev_b;
            end
            debug_trigger_pkg::MODE_A_THEN_B: begin
                // A flag is registered, so A must come in an earlier cycle
                trig_ev = ev_b && s.a_flag;
            end
            debug_trigger_pkg::MODE_EVT_B: begin
                trig_ev = ev_b;
            end
            debug_trigger_pkg::MODE_A_THEN_EVT: begin
                trig_ev = ev_b && s.a_flag;
            end
            debug_trigger_pkg::MODE_FULL_AND: begin
                trig_ev = ev_a && data_eq;
            end
            debug_trigger_pkg::MODE_FULL_NAND: begin
                trig_ev = ev_a && !data_eq;
            end
            debug_trigger_pkg::MODE_INSIDE: begin
                trig_ev = cyc_ok && bus_i.addr >= s.comp_a && bus_i.addr <= s.comp_b;
            end
            debug_trigger_pkg::MODE_OUTSIDE: begin
                trig_ev = cyc_ok && (bus_i.addr < s.comp_a || bus_i.addr > s.comp_b);
            end
            default: begin
                // Unused codes never trigger
                trig_ev = 1'b0;
            end
        endcase
    end

    // =========================================================
    // Breakpoint source
    assign tag_sel = s.ctrl[debug_trigger_pkg::CTRL_TAG];
    // Tag request in full modes rides on the A address alone
    assign brk_ev  = (full_mode && tag_sel) ? ev_a : trig_ev;

    // =========================================================
    // FIFO word selection
    always_comb begin
        if (event_mode) begin
            // Data byte of the actual transfer, low half only
            push_word = {8'h00, bus_i.rw ? bus_i.rdata : bus_i.wdata};
        end else begin
            push_word = cof_addr_i;
        end
    end

    always_comb begin
        if (!s.armed) begin
            push = 1'b0;
        end else if (event_mode) begin
            push = trig_ev;
        end else if (end_trace) begin
            push = cof_valid_i;
        end else begin
            push = cof_valid_i && s.storing;
        end
    end

    assign full = s.count == debug_trigger_pkg::CNT_FULL;
    assign pop  = reg_rd_i && reg_addr_i == debug_trigger_pkg::OFS_FIFO && s.count != '0;

    // =========================================================
    // Next state
    always_comb begin
        next_s      = s;
        next_s.rdata = '0;
        next_s.bkpt  = '0;

        // Match flags and breakpoints only while a run is live
        if (s.armed) begin
            if (ev_a) begin
                next_s.a_flag = 1'b1;
            end
            if (ev_b) begin
                next_s.b_flag = 1'b1;
            end
            if (s.ctrl[debug_trigger_pkg::CTRL_BRK_EN] && brk_ev) begin
                next_s.bkpt.tag       = tag_sel;
                next_s.bkpt.force_brk = !tag_sel;
                next_s.bkpt.use_swi   = !background_permit_i;
            end
        end

        // Circular overwrite keeps the newest eight words
        if (push) begin
            next_s.fifo[s.wptr] = push_word;
            next_s.wptr = s.wptr + 1'b1;
        end
        if (push && full) begin
            next_s.rptr = s.rptr + 1'b1;
        end else begin
            next_s.rptr  = s.rptr + {2'b00, pop};
            next_s.count = s.count + {3'b000, push} - {3'b000, pop};
        end

        // Run sequencing
        if (s.armed) begin
            if (!end_trace && !s.storing && trig_ev) begin
                next_s.storing = 1'b1;
            end
            if (end_trace && trig_ev) begin
                next_s.armed = 1'b0;
            end
            if (!end_trace && next_s.count == debug_trigger_pkg::CNT_FULL) begin
                next_s.armed = 1'b0;
            end
        end

        // Register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                debug_trigger_pkg::OFS_COMP_A: begin
                    next_s.comp_a = reg_wdata_i;
                end
                debug_trigger_pkg::OFS_COMP_B: begin
                    next_s.comp_b = reg_wdata_i;
                end
                debug_trigger_pkg::OFS_CTRL: begin
                    next_s.ctrl = reg_wdata_i[7:0];
                    if (!reg_wdata_i[debug_trigger_pkg::CTRL_ARM] ||
                        !reg_wdata_i[debug_trigger_pkg::CTRL_ENABLE]) begin
                        next_s.armed = 1'b0;
                    end else begin
                        next_s.armed   = 1'b1;
                        next_s.a_flag  = 1'b0;
                        next_s.b_flag  = 1'b0;
                        next_s.count   = '0;
                        next_s.wptr    = '0;
                        next_s.rptr    = '0;
                        next_s.storing = 1'b0;
                    end
                end
                debug_trigger_pkg::OFS_TRIG: begin
                    next_s.trig = reg_wdata_i[7:0];
                end
                default: begin
                    // Status and FIFO are read only
                end
            endcase
        end

        // Register reads, data in the following cycle only
        if (reg_rd_i) begin
            case (reg_addr_i)
                debug_trigger_pkg::OFS_COMP_A: begin
                    next_s.rdata = s.comp_a;
                end
                debug_trigger_pkg::OFS_COMP_B: begin
                    next_s.rdata = s.comp_b;
                end
                debug_trigger_pkg::OFS_CTRL: begin
                    next_s.rdata = {8'h00, s.ctrl};
                end
                debug_trigger_pkg::OFS_TRIG: begin
                    next_s.rdata = {8'h00, s.trig};
                end
                debug_trigger_pkg::OFS_STAT: begin
                    next_s.rdata = {8'h00, s.a_flag, s.b_flag, s.armed, 1'b0, s.count};
                end
                debug_trigger_pkg::OFS_FIFO: begin
                    if (s.count != '0) begin
                        next_s.rdata = s.fifo[s.rptr];
                    end
                end
                default: begin
                    next_s.rdata = '0;
                end
            endcase
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s        <= '0;
            s.comp_a <= debug_trigger_pkg::COMP_RESET;
            s.comp_b <= debug_trigger_pkg::COMP_RESET;
            s.ctrl   <= debug_trigger_pkg::CTRL_RESET;
            s.trig   <= debug_trigger_pkg::TRIG_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata_o = s.rdata;
    assign bkpt_o      = s.bkpt;
endmodule // debug_trigger_breakpoint_logic

/* verification/debug_trigger_assertions.sv */
`timescale 1ns/1ps
module debug_trigger_checker (
    // Clock and reset
    input wire logic                         clk_i,
    input wire logic                         rst_i,
    // Observed ports
    input wire logic [2:0]                   reg_addr_i,
    input wire logic [15:0]                  reg_wdata_i,
    input wire logic                         reg_wr_i,
    input wire logic                         reg_rd_i,
    input wire logic [15:0]                  reg_rdata_o,
    input wire debug_trigger_pkg::cpu_bus_t  bus_i,
    input wire debug_trigger_pkg::queue_ev_t queue_i,
    input wire logic                         background_permit_i,
    input wire debug_trigger_pkg::bkpt_req_t bkpt_o
);
    // ==========================================================
    // Control mirror, delayed to line up with the registered break
    logic [7:0] ctl;
    logic [7:0] ctl_d;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl <= 8'h00;
            ctl_d <= 8'h00;
        end else begin
            ctl_d <= ctl;
            if (reg_wr_i && reg_addr_i == debug_trigger_pkg::OFS_CTRL) ctl <= reg_wdata_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Sequences
    sequence quiet_s;
        !(bus_i.valid && !bus_i.bdc) && !queue_i.pop;
    endsequence
    sequence disarm_s;
        reg_wr_i && reg_addr_i == debug_trigger_pkg::OFS_CTRL
            && !(reg_wdata_i[debug_trigger_pkg::CTRL_ARM] && reg_wdata_i[debug_trigger_pkg::CTRL_ENABLE])
            ##1 !queue_i.pop;
    endsequence
    // ==========================================================
    // Properties
    reset_clear_a: assert property ($fell(rst_i) |-> bkpt_o == '0 && reg_rdata_o == 16'h0000)
        else $error("outputs not clear after reset");
    idle_bus_a: assert property (quiet_s |=> bkpt_o == '0)
        else $error("break without a bus cycle");
    bdc_blind_a: assert property (bus_i.valid && bus_i.bdc && !queue_i.pop |=>
        !bkpt_o.tag && !bkpt_o.force_brk)
        else $error("break on background access");
    swi_select_a: assert property (bkpt_o.tag || bkpt_o.force_brk |->
        bkpt_o.use_swi == !$past(background_permit_i))
        else $error("software interrupt choice wrong");
    one_type_a: assert property ($onehot0({bkpt_o.tag, bkpt_o.force_brk}) &&
        (!bkpt_o.use_swi || bkpt_o.tag || bkpt_o.force_brk))
        else $error("break type encoding wrong");
    brk_gate_a: assert property (bkpt_o.tag || bkpt_o.force_brk |->
        ctl_d[debug_trigger_pkg::CTRL_BRK_EN] && bkpt_o.tag == ctl_d[debug_trigger_pkg::CTRL_TAG])
        else $error("break type or enable wrong");
    disarm_stop_a: assert property (disarm_s |=> bkpt_o == '0)
        else $error("break after disarm");
    upper_zero_a: assert property (reg_rd_i && reg_addr_i inside {[3'h2:3'h4]} |=>
        reg_rdata_o[15:8] == 8'h00)
        else $error("upper byte of control read not zero");
    read_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data outside read cycle");
endmodule // debug_trigger_checker
bind debug_trigger_breakpoint_logic debug_trigger_checker chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .bus_i(bus_i),
    .queue_i(queue_i), .background_permit_i(background_permit_i), .bkpt_o(bkpt_o)
);

/* verification/cpu_queue_model.sv */
`timescale 1ns/1ps
module cpu_queue_model (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // Push, pop, flush requests and the break input
    input  wire logic [2:0]                   ev_i,
    input  wire debug_trigger_pkg::bkpt_req_t bkpt_i,
    // Queue events and breaks taken
    output debug_trigger_pkg::queue_ev_t      queue_o,
    output logic [3:0]                        background_opcode_o,
    output logic [3:0]                        swi_o
);
    logic [1:0] q[$];
    logic [1:0] h;
    assign queue_o = ev_i;
    always @(posedge clk_i) begin
        if (rst_i || ev_i[0]) q.delete();
        if (ev_i[2]) q.push_back(2'b00);
        // A tag lands on the newest opcode; an empty queue drops it
        if (bkpt_i.tag && q.size() > 0) q[q.size() - 1] = {1'b1, bkpt_i.use_swi};
        h = (ev_i[1] && q.size() > 0) ? q.pop_front() : 2'b00;
        if (rst_i) begin
            background_opcode_o <= 4'h0;
            swi_o <= 4'h0;
        end else if (bkpt_i.force_brk || h[1]) begin
            if (bkpt_i.force_brk ? bkpt_i.use_swi : h[0]) swi_o <= swi_o + 4'h1;
            else background_opcode_o <= background_opcode_o + 4'h1;
        end
    end
endmodule // cpu_queue_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    // ==========================================================
    // Signals
    logic                          clk_i, rst_i, reg_wr, reg_rd, permit, rd_d;
    logic                          tg, bg, pm, seen, ma, mb, hit;
    logic [2:0]                    reg_addr;
    logic [3:0]                    ev, cf, n, s0, background_opcode, software_interrupt_instr;
    logic [7:0]                    dv;
    logic [15:0]                   reg_wdata, reg_rdata, a, b, p, d16;
    logic [31:0]                   e;
    debug_trigger_pkg::cpu_bus_t   bus, x;
    debug_trigger_pkg::queue_ev_t  queue;
    debug_trigger_pkg::bkpt_req_t  bkpt;
    logic [31:0]                   exp_q[$];
    logic [2:0]                    brk_q[$];
    logic [15:0]                   dq[$];
    int                            failures, check_count, cycles;
    localparam debug_trigger_pkg::cpu_bus_t FETCH_A = {16'h1234, 16'h0000, 3'b110};
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    debug_trigger_breakpoint_logic dut_u (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .bus_i(bus), .queue_i(queue), .cof_valid_i(ev[0]), .cof_addr_i(reg_wdata),
        .background_permit_i(permit), .bkpt_o(bkpt));
    cpu_queue_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .ev_i(ev[3:1]), .bkpt_i(bkpt),
        .queue_o(queue), .background_opcode_o(background_opcode), .swi_o(software_interrupt_instr));
    // ==========================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        check_count++;
        if (got !== want) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic finish_test();
        $display("Counts: %0d checks, %0d failures", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Every input is set once per cycle, so back-to-back strobes never double-assign
    task automatic step(input logic [3:0] v, input logic w, input logic r, input logic [2:0] ad,
                        input logic [15:0] d, input debug_trigger_pkg::cpu_bus_t bb);
        {ev, reg_wr, reg_rd, reg_addr, reg_wdata, bus} <= {v, w, r, ad, d, bb};
        @(posedge clk_i);
    endtask
    task automatic idle();
        step(4'h0, 1'b0, 1'b0, 3'h0, 16'h0000, '0);
    endtask
    task automatic wr(input logic [2:0] ad, input logic [15:0] d);
        step(4'h0, 1'b1, 1'b0, ad, d, '0);
    endtask
    task automatic rd(input logic [2:0] ad, input logic [31:0] mv);
        exp_q.push_back(mv);
        step(4'h0, 1'b0, 1'b1, ad, 16'h0000, '0);
    endtask
    task automatic drain();
        while (dq.size() > 0) rd(debug_trigger_pkg::OFS_FIFO, {16'hFFFF, dq.pop_front()});
    endtask
    task automatic reset_check();
        rst_i <= 1'b1;
        repeat (6) idle();
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) rd(3'(i), {16'hFFFF, 16'h0000});
    endtask
    // ==========================================================
    // Result watcher
    always @(posedge clk_i) begin
        rd_d <= reg_rd && !rst_i;
        cycles++;
        if (rd_d) begin
            e = exp_q.pop_front();
            chk(reg_rdata & e[31:16], e[15:0]);
        end
        if (!rst_i && bkpt !== 3'b000) begin
            chk({13'h0, bkpt}, brk_q.size() > 0 ? {13'h0, brk_q.pop_front()} : 16'h0000);
        end
        if (cycles > 5000) begin
            failures++;
            finish_test();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        rst_i = 1'b1;
        permit = 1'b0;
        {ev, reg_wr, reg_rd, reg_addr, reg_wdata, bus} = '0;
        void'($urandom(54));
        reset_check();
        for (int m = 0; m < 10; m++) begin
            a = 16'($urandom_range(4000, 16));
            b = a + 16'($urandom_range(20, 2));
            tg = 1'($urandom);
            cf = 4'($urandom);
            pm = 1'($urandom);
            bg = (m == 3 || m == 4) ? 1'($urandom) : 1'b1;
            permit <= pm;
            wr(debug_trigger_pkg::OFS_COMP_A, a);
            wr(debug_trigger_pkg::OFS_COMP_B, b);
            rd(debug_trigger_pkg::OFS_COMP_B, {16'hFFFF, b});
            wr(debug_trigger_pkg::OFS_TRIG, {8'h00, 1'b0, bg, 2'b00, 4'(m)});
            wr(debug_trigger_pkg::OFS_CTRL, {8'h00, 2'b11, tg, 1'b1, cf});
            seen = 1'b0;
            n = 4'h0;
            repeat (6) begin
                p = (($urandom_range(1, 0) == 1) ? a : b) + 16'($urandom_range(2, 0)) - 16'h0001;
                x = {p, 8'($urandom), 8'($urandom), 1'($urandom), 1'b1, 1'($urandom_range(3, 0) == 0)};
                ma = !x.bdc && x.addr == a && (!cf[3] || x.rw == cf[2]);
                mb = !x.bdc && x.addr == b && (!cf[1] || x.rw == cf[0]);
                dv = (cf[3] && !cf[2]) ? x.wdata : x.rdata;
                case (m)
                    0: hit = ma;
                    1: hit = ma || mb;
                    2: hit = mb && seen;
                    3: hit = mb;
                    4: hit = mb && seen;
                    5: hit = ma && (dv == b[7:0] || tg);
                    6: hit = ma && (dv != b[7:0] || tg);
                    7: hit = !x.bdc && x.addr >= a && x.addr <= b;
                    8: hit = !x.bdc && (x.addr < a || x.addr > b);
                    default: hit = 1'b0;
                endcase
                if (hit) brk_q.push_back({tg, !tg, !pm});
                if (hit && (m == 3 || m == 4)) dq.push_back({8'h00, x.rw ? x.rdata : x.wdata});
                if (hit && (m == 3 || m == 4)) n++;
                seen = seen | ma;
                step(4'h0, 1'b0, 1'b0, 3'h0, 16'h0000, x);
            end
            idle();
            rd(debug_trigger_pkg::OFS_STAT, {16'hFF2F, 8'h00, 4'h2, n});
            drain();
            wr(debug_trigger_pkg::OFS_CTRL, ($urandom_range(1, 0) == 1) ? 16'h0090 : 16'h0050);
            step(4'h0, 1'b0, 1'b0, 3'h0, 16'h0000, {a, 16'h0000, 3'b110});
            rd(debug_trigger_pkg::OFS_STAT, {16'hFF20, 16'h0000});
        end
        // End trace: circular store from arm, run closes on the trigger
        wr(debug_trigger_pkg::OFS_COMP_A, 16'h1234);
        wr(debug_trigger_pkg::OFS_TRIG, 16'h0000);
        wr(debug_trigger_pkg::OFS_CTRL, 16'h00D0);
        for (int i = 0; i < 4; i++) begin
            d16 = 16'($urandom);
            dq.push_back(d16);
            if (i == 3) brk_q.push_back({2'b01, !pm});
            step(4'h1, 1'b0, 1'b0, 3'h0, d16, (i == 3) ? FETCH_A : '0);
        end
        idle();
        step(4'h0, 1'b0, 1'b0, 3'h0, 16'h0000, FETCH_A);
        rd(debug_trigger_pkg::OFS_STAT, {16'hFF2F, 16'h0004});
        drain();
        // Opcode tracking: two fetches pending, a flushed fetch never breaks
        pm = 1'b0;
        permit <= 1'b0;
        s0 = software_interrupt_instr;
        wr(debug_trigger_pkg::OFS_TRIG, 16'h00C0);
        wr(debug_trigger_pkg::OFS_CTRL, 16'h00D0);
        repeat (2) step(4'h8, 1'b0, 1'b0, 3'h0, 16'h0000, FETCH_A);
        idle();
        repeat (2) begin
            brk_q.push_back(3'b011);
            step(4'h4, 1'b0, 1'b0, 3'h0, 16'h0000, '0);
        end
        step(4'h8, 1'b0, 1'b0, 3'h0, 16'h0000, FETCH_A);
        step(4'h2, 1'b0, 1'b0, 3'h0, 16'h0000, '0);
        repeat (3) idle();
        chk({12'h000, software_interrupt_instr - s0}, 16'h0002);
        // Tag break: opcode marked at fetch, swapped when it executes
        pm = 1'b1;
        permit <= 1'b1;
        s0 = background_opcode;
        wr(debug_trigger_pkg::OFS_TRIG, 16'h0040);
        wr(debug_trigger_pkg::OFS_CTRL, 16'h00F0);
        brk_q.push_back(3'b100);
        step(4'h8, 1'b0, 1'b0, 3'h0, 16'h0000, FETCH_A);
        idle();
        step(4'h4, 1'b0, 1'b0, 3'h0, 16'h0000, '0);
        repeat (2) idle();
        chk({12'h000, background_opcode - s0}, 16'h0001);
        reset_check();
        repeat (3) idle();
        chk(16'(brk_q.size()), 16'h0000);
        finish_test();
    end
endmodule // tb
